// ==== pkg/psr_consts.vh ====
// register offsets, field positions, reset values for pin select and readback block
`ifndef PSR_CONSTS_VH
`define PSR_CONSTS_VH
`define PSR_OFS_PORTA_DATA 12'h000
`define PSR_OFS_PORTA_DIR 12'h004
`define PSR_OFS_PORTB_DATA 12'h008
`define PSR_OFS_PORTB_DIR 12'h00C
`define PSR_OFS_PB_FUNC_HI 12'h010
`define PSR_OFS_IN_SRC 12'h014
`define PSR_OFS_RB_KEY 12'h018
`define PSR_OFS_WAKE_EN 12'h01C
`define PSR_OFS_ANA_SEL 12'h020
`define PSR_OFS_ADC_CHAN 12'h024
`define PSR_OFS_MODE 12'h028
`define PSR_RST_DATA 8'hFF
`define PSR_RST_DIR 8'hFF
`define PSR_RST_SEL 8'h00
`define PSR_RB_KEY_VAL 8'hCA
`define PSR_FUNC_GPIO 2'h0
`define PSR_FUNC_CMP 2'h1
`define PSR_FUNC_ANA 2'h2
`define PSR_FUNC_SCL 2'h3
`define PSR_BIT_SCL_SRC 1
`define PSR_BIT_SDA_SRC 0
`define PSR_PB4_ANA_CHAN 4'h3
`endif

// ==== rtl/psr_sync.v ====
// two-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
module psr_sync #(
	parameter W = 8
) (
	input wire hclk,
	input wire hresetn,
	input wire [W-1:0] d,
	output reg [W-1:0] q
);
	reg [W-1:0] meta_q;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			// idle-high pins: no false falling edge after reset
			meta_q <= {W{1'b1}};
			q <= {W{1'b1}};
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule // psr_sync

// ==== rtl/psr_pin_select.v ====
// port pin function select, serial input routing, readback mode and wake-up
`timescale 1ns/1ps
`include "psr_consts.vh"
module psr_pin_select #(
	parameter W = 8
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	input wire [W-1:0] porta_pin_in,
	input wire [W-1:0] portb_pin_in,
	output reg [W-1:0] porta_pin_out,
	output reg [W-1:0] porta_pin_oe_n,
	output reg [W-1:0] portb_pin_out,
	output reg [W-1:0] portb_pin_oe_n,
	input wire comparator0_output,
	output reg serial_clk_in,
	output reg serial_data_in,
	output reg [2*W-1:0] analog_path_on,
	output reg readback_active,
	output reg wake_req
);
	reg [W-1:0] pa_data_q, pa_dir_q, pb_data_q, pb_dir_q;
	reg [1:0] pin_b4_func_bits;
	reg serial_clk_pin_choice, serial_data_pin_choice;
	reg [7:0] readback_key_bits;
	reg [W-1:0] wake_en_q;
	reg [2*W-1:0] ana_sel_q;
	reg [3:0] adc_chan_q;
	reg low_power_q;
	reg [W-1:0] pa_prev_q;
	reg wr_pend_q;
	reg [11:0] wr_addr_q;
	wire [W-1:0] pa_s, pb_s;
	reg [31:0] rd_d;
	reg [W-1:0] pa_rd, pb_rd;
	reg [2*W-1:0] ana_d;
	reg [W-1:0] pb_out_d, pb_oe_d;
	integer i;

	psr_sync #(.W(W)) u_sync_a (.hclk(hclk), .hresetn(hresetn), .d(porta_pin_in), .q(pa_s));
	psr_sync #(.W(W)) u_sync_b (.hclk(hclk), .hresetn(hresetn), .d(portb_pin_in), .q(pb_s));

	wire addr_ph = hsel & hready & htrans[1];
	wire key_ok = (readback_key_bits == `PSR_RB_KEY_VAL);
	wire pb4_ana = (pin_b4_func_bits == `PSR_FUNC_ANA);
	wire pb4_dig = (pin_b4_func_bits == `PSR_FUNC_GPIO);
	wire pb4_scl = (pin_b4_func_bits == `PSR_FUNC_SCL);

	// port read data per pin
	always @* begin
		for (i = 0; i < W; i = i + 1) begin
			if (readback_active || pa_dir_q[i]) begin
				pa_rd[i] = pa_s[i];
			end else begin
				pa_rd[i] = pa_data_q[i];
			end
			if (ana_sel_q[i] && !readback_active) begin
				pa_rd[i] = 1'b0;
			end
			if (readback_active || pb_dir_q[i]) begin
				pb_rd[i] = pb_s[i];
			end else begin
				pb_rd[i] = pb_data_q[i];
			end
			if (ana_sel_q[W+i] && !readback_active) begin
				pb_rd[i] = 1'b0;
			end
		end
		if (!readback_active) begin
			if (pb4_ana) begin
				pb_rd[4] = 1'b0;
			end else if (pb4_scl) begin
				pb_rd[4] = pb_s[4];
			end
		end
	end

	// register read mux
	always @* begin
		rd_d = 32'h0000_0000;
		case (haddr[11:0])
		`PSR_OFS_PORTA_DATA: rd_d[W-1:0] = pa_rd;
		`PSR_OFS_PORTA_DIR: rd_d[W-1:0] = pa_dir_q;
		`PSR_OFS_PORTB_DATA: rd_d[W-1:0] = pb_rd;
		`PSR_OFS_PORTB_DIR: rd_d[W-1:0] = pb_dir_q;
		`PSR_OFS_PB_FUNC_HI: rd_d[1:0] = pin_b4_func_bits;
		`PSR_OFS_IN_SRC: rd_d[1:0] = {serial_clk_pin_choice, serial_data_pin_choice};
		`PSR_OFS_RB_KEY: rd_d[7:0] = readback_key_bits;
		`PSR_OFS_WAKE_EN: rd_d[W-1:0] = wake_en_q;
		`PSR_OFS_ANA_SEL: rd_d[2*W-1:0] = ana_sel_q;
		`PSR_OFS_ADC_CHAN: rd_d[3:0] = adc_chan_q;
		`PSR_OFS_MODE: rd_d[0] = low_power_q;
		default: rd_d = 32'h0000_0000;
		endcase
	end

	// analog path enables; index W+4 is pin b4 on channel 3
	always @* begin
		for (i = 0; i < 2*W; i = i + 1) begin
			ana_d[i] = ana_sel_q[i] && (adc_chan_q == i[3:0]);
		end
		ana_d[W+4] = pb4_ana && (adc_chan_q == `PSR_PB4_ANA_CHAN);
		if (readback_active) begin
			ana_d = {2*W{1'b1}};
		end
	end

	// port b pin drive
	always @* begin
		pb_out_d = pb_data_q;
		pb_oe_d = pb_dir_q;
		if (pb4_dig) begin
			pb_out_d[4] = pb_data_q[4];
		end else if (pin_b4_func_bits == `PSR_FUNC_CMP) begin
			pb_out_d[4] = comparator0_output;
			pb_oe_d[4] = 1'b0;
		end else begin
			pb_oe_d[4] = 1'b1;
		end
		pb_oe_d = pb_oe_d | ana_sel_q[2*W-1:W];
		pb_oe_d[4] = pb_oe_d[4] | pb4_ana | pb4_scl;
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pa_data_q <= {W{1'b1}};
			pa_dir_q <= {W{1'b1}};
			pb_data_q <= {W{1'b1}};
			pb_dir_q <= {W{1'b1}};
			pin_b4_func_bits <= 2'h0;
			serial_clk_pin_choice <= 1'b0;
			serial_data_pin_choice <= 1'b0;
			readback_key_bits <= `PSR_RST_SEL;
			wake_en_q <= {W{1'b0}};
			ana_sel_q <= {2*W{1'b0}};
			adc_chan_q <= 4'h0;
			low_power_q <= 1'b0;
			wr_pend_q <= 1'b0;
			wr_addr_q <= 12'h000;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wr_pend_q <= addr_ph & hwrite;
			if (addr_ph) begin
				wr_addr_q <= haddr[11:0];
			end
			if (addr_ph && !hwrite) begin
				hrdata <= rd_d;
			end
			if (wr_pend_q) begin
				case (wr_addr_q)
				`PSR_OFS_PORTA_DATA: pa_data_q <= hwdata[W-1:0];
				`PSR_OFS_PORTA_DIR: pa_dir_q <= hwdata[W-1:0];
				`PSR_OFS_PORTB_DATA: pb_data_q <= hwdata[W-1:0];
				`PSR_OFS_PORTB_DIR: pb_dir_q <= hwdata[W-1:0];
				`PSR_OFS_PB_FUNC_HI: pin_b4_func_bits <= hwdata[1:0];
				`PSR_OFS_IN_SRC: begin
					serial_clk_pin_choice <= hwdata[`PSR_BIT_SCL_SRC];
					serial_data_pin_choice <= hwdata[`PSR_BIT_SDA_SRC];
				end
				`PSR_OFS_RB_KEY: readback_key_bits <= hwdata[7:0];
				`PSR_OFS_WAKE_EN: wake_en_q <= hwdata[W-1:0];
				`PSR_OFS_ANA_SEL: ana_sel_q <= hwdata[2*W-1:0];
				`PSR_OFS_ADC_CHAN: adc_chan_q <= hwdata[3:0];
				`PSR_OFS_MODE: low_power_q <= hwdata[0];
				default: ;
				endcase
			end
		end
	end

	// pin side registers
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pa_prev_q <= {W{1'b1}};
			porta_pin_out <= {W{1'b1}};
			porta_pin_oe_n <= {W{1'b1}};
			portb_pin_out <= {W{1'b1}};
			portb_pin_oe_n <= {W{1'b1}};
			serial_clk_in <= 1'b1;
			serial_data_in <= 1'b1;
			analog_path_on <= {2*W{1'b0}};
			readback_active <= 1'b0;
			wake_req <= 1'b0;
		end else begin
			pa_prev_q <= pa_s;
			readback_active <= key_ok;
			porta_pin_out <= pa_data_q;
			porta_pin_oe_n <= pa_dir_q | ana_sel_q[W-1:0];
			portb_pin_out <= pb_out_d;
			portb_pin_oe_n <= pb_oe_d;
			serial_clk_in <= serial_clk_pin_choice ? pb_s[4] : pa_s[2];
			serial_data_in <= serial_data_pin_choice ? pb_s[0] : pa_s[0];
			analog_path_on <= ana_d;
			wake_req <= low_power_q && |(pa_prev_q & ~pa_s & wake_en_q);
		end
	end
endmodule // psr_pin_select

// ==== test/psr_pin_board.sv ====
// board side of the port pins: driven pins show the drive, released pins the board level
`timescale 1ns/1ps
module psr_pin_board #(
	parameter W = 8
) (
	input wire [W-1:0] drv,
	input wire [W-1:0] oe_n,
	input wire [W-1:0] lvl,
	output wire [W-1:0] pin
);
	assign pin = (drv & ~oe_n) | (lvl & oe_n);
endmodule // psr_pin_board

// ==== test/psr_pin_select_sva.sv ====
// port-level checker for the pin select and readback block
`timescale 1ns/1ps
module psr_pin_select_sva #(
	parameter W = 8
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [31:0] hrdata,
	input wire hreadyout,
	input wire hresp,
	input wire [W-1:0] porta_pin_in,
	input wire [2*W-1:0] analog_path_on,
	input wire readback_active,
	input wire wake_req
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	reg rq;
	reg [11:0] aq;
	// read data phase tracker
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			rq <= 1'h0;
		else
			rq <= hsel & htrans[1] & !hwrite & hreadyout;
	end
	always @(posedge hclk)
		aq <= haddr[11:0];
	a_resp_okay: assert property (!hresp) else $error("bad resp");
	a_ready_high: assert property (hreadyout) else $error("wait state");
	a_func_hi_zero: assert property (rq && aq == 12'h010 |-> hrdata[31:2] == 30'h0)
		else $error("func hi bits");
	a_src_hi_zero: assert property (rq && aq == 12'h014 |-> hrdata[31:2] == 30'h0)
		else $error("source hi bits");
	a_key_width: assert property (rq && aq == 12'h018 |-> hrdata[31:8] == 24'h0)
		else $error("key hi bits");
	a_wake_pulse: assert property (wake_req |=> !wake_req) else $error("wake long");
	a_wake_fall: assert property (wake_req |-> |($past(porta_pin_in, 4) & ~$past(porta_pin_in, 3)))
		else $error("wake no fall");
	a_rb_force: assert property (readback_active ##1 readback_active |-> &analog_path_on)
		else $error("analog not forced");
	cover property (rq);
	cover property (wake_req);
	cover property (readback_active);
endmodule // psr_pin_select_sva
bind psr_pin_select psr_pin_select_sva #(.W(W)) u_sva (.*);

// ==== test/test_pin_select_readback_check.sv ====
// self-checking bench for the pin select and readback block
`timescale 1ns/1ps
`include "psr_consts.vh"
module test_pin_select_readback_check;
	reg hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, mr = 1'h0, wk;
	reg comparator0_output = 1'h0;
	reg [1:0] htrans = 2'h0;
	reg [31:0] haddr = 32'h0, hwdata = 32'h0, rnd = 32'hAB78E963;
	reg [7:0] pa = 8'hFF, pb = 8'hFF, k;
	int bad_count = 0, total_checks = 0, i;
	logic [31:0] exp_q[$];
	wire [31:0] hrdata;
	wire hreadyout, hresp, serial_clk_in, serial_data_in, readback_active, wake_req;
	wire [7:0] porta_pin_in, portb_pin_in, porta_pin_out, porta_pin_oe_n, portb_pin_out, portb_pin_oe_n;
	wire [15:0] analog_path_on;
	psr_pin_select u_dut (.hsize(3'h2), .hready(hreadyout), .*);
	psr_pin_board u_pa (.drv(porta_pin_out), .oe_n(porta_pin_oe_n), .lvl(pa), .pin(porta_pin_in));
	psr_pin_board u_pb (.drv(portb_pin_out), .oe_n(portb_pin_oe_n), .lvl(pb), .pin(portb_pin_in));
	initial forever #20 hclk = ~hclk;
	function [31:0] lf(input [31:0] s);
		lf = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task chk(input [31:0] g, input [31:0] e);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task xfer(input [11:0] a, input w, input [31:0] d);
		hsel <= 1'h1;
		haddr <= {20'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
	endtask
	task rd(input [11:0] a, input [31:0] e);
		exp_q.push_back(e);
		xfer(a, 1'h0, 32'h0);
	endtask
	task finish_test;
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// read results are compared in the data phase, oldest note first
	always @(posedge hclk) begin
		if (mr)
			chk(hrdata, exp_q.pop_front());
		mr <= hsel & htrans[1] & !hwrite & hreadyout;
	end
	initial begin
		repeat (3000) @(posedge hclk);
		bad_count++;
		finish_test;
	end
	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		xfer(`PSR_OFS_PORTA_DIR, 1'h1, 32'h0);
		rd(`PSR_OFS_PORTA_DATA, 32'hFF);
		chk(32'(porta_pin_oe_n), 32'h0);
		chk(32'(porta_pin_out), 32'hFF);
		rnd = lf(rnd);
		xfer(`PSR_OFS_PORTA_DATA, 1'h1, 32'(rnd[7:0]));
		rd(`PSR_OFS_PORTA_DATA, 32'(rnd[7:0]));
		xfer(`PSR_OFS_PORTA_DIR, 1'h1, 32'hFF);
		pa <= rnd[15:8];
		repeat (3) @(posedge hclk);
		rd(`PSR_OFS_PORTA_DATA, 32'(rnd[15:8]));
		xfer(`PSR_OFS_PORTB_DIR, 1'h1, 32'hEF);
		comparator0_output <= rnd[31];
		for (i = 0; i < 4; i++) begin
			xfer(`PSR_OFS_PB_FUNC_HI, 1'h1, 32'hFC | i);
			rd(`PSR_OFS_PB_FUNC_HI, i);
			if (i == 1) begin
				chk(32'(portb_pin_out[4]), 32'(rnd[31]));
				chk(32'(portb_pin_oe_n), 32'hEF);
			end
			if (i == 2)
				rd(`PSR_OFS_PORTB_DATA, 32'hEF);
		end
		xfer(`PSR_OFS_PB_FUNC_HI, 1'h1, 32'h0);
		xfer(`PSR_OFS_PORTB_DIR, 1'h1, 32'hFF);
		for (i = 0; i < 4; i++) begin
			rnd = lf(rnd);
			pa <= rnd[7:0];
			pb <= rnd[15:8];
			xfer(`PSR_OFS_IN_SRC, 1'h1, i);
			repeat (4) @(posedge hclk);
			chk(32'(serial_clk_in), 32'(i[1] ? rnd[12] : rnd[2]));
			chk(32'(serial_data_in), 32'(i[0] ? rnd[8] : rnd[0]));
		end
		k = (rnd[23:16] == 8'hCA) ? 8'hCB : rnd[23:16];
		for (i = 0; i < 3; i++) begin
			if (i > 0)
				k = (i == 1) ? 8'hCB : 8'hCA;
			xfer(`PSR_OFS_RB_KEY, 1'h1, 32'(k));
			rd(`PSR_OFS_RB_KEY, 32'(k));
			chk(32'(readback_active), 32'(i == 2));
		end
		xfer(`PSR_OFS_ANA_SEL, 1'h1, 32'hFF);
		repeat (3) @(posedge hclk);
		rd(`PSR_OFS_PORTA_DATA, 32'(rnd[7:0]));
		chk(32'(analog_path_on), 32'hFFFF);
		xfer(`PSR_OFS_RB_KEY, 1'h1, 32'h0);
		// readback flag is registered: let it fall before the read
		@(posedge hclk);
		rd(`PSR_OFS_PORTA_DATA, 32'h0);
		chk(32'(analog_path_on), 32'h0000_0001);
		xfer(`PSR_OFS_ANA_SEL, 1'h1, 32'h0);
		xfer(`PSR_OFS_MODE, 1'h1, 32'h1);
		for (i = 0; i < 2; i++) begin
			xfer(`PSR_OFS_WAKE_EN, 1'h1, i);
			pa <= 8'hFF;
			repeat (4) @(posedge hclk);
			pa <= 8'hFE;
			wk = 1'h0;
			repeat (6) @(posedge hclk) wk = wk | wake_req;
			chk(32'(wk), i);
		end
		finish_test;
	end
endmodule // test_pin_select_readback_check
